// ---- charger_control_regs_4_5.sv ----
// What this block does
// - switch B drive enable, locked 0 if unfitted
// - switch A drive enable, locked 0 if unfitted
// - rate select; power-on from strap pin
// - indicator pin off bit; watchdog clears
// - system short guard off; no watchdog clear
// - detect request accepted only battery above minimum
// - detect request drives stop, measure, update
// - detect request clears itself when done
// - input overcurrent guard enable, resets to 1
// - ship bits held 0 while unfitted
// - battery current output enable; watchdog clears
// - internal current limit enable resets 1
// - pin current limit enable resets 1
// - discharge overcurrent enable resets 0
// - drive kill forces both switch enables 0
`timescale 1ns/1ps
module charger_control_regs_4_5 (
    // clock and reset
    input wire logic clock_i,
    input wire logic reset_n_i,
    // register access from serial interface
    input wire charger_ctrl_pkg::reg_req_t req_i,
    output logic [7:0] rdata_o,
    // soft resets
    input wire logic register_reset_i,
    input wire logic watchdog_expired_i,
    // pins and analog status
    input wire logic configuration_strap_pin_i,
    input wire logic switch_pair_a_fitted_i,
    input wire logic switch_pair_b_fitted_i,
    input wire logic battery_above_minimum_i,
    input wire logic detect_done_i,
    // from other control registers
    input wire logic input_switch_drive_kill_i,
    input wire logic ship_force_off_req_i,
    input wire logic [1:0] ship_action_req_i,
    // controls out
    output charger_ctrl_pkg::charger_ctrl_t ctrl_o,
    output logic detect_stop_switching_o,
    output logic ship_force_off_o,
    output logic [1:0] ship_action_o
);

    // ****************************************
    // input synchronisers
    // ****************************************
    logic strap_s;
    logic fit_a_s;
    logic fit_b_s;
    logic batt_ok_s;

    sync_bit u_sync_strap (
        .clock_i(clock_i),
        .reset_n_i(reset_n_i),
        .d_i(configuration_strap_pin_i),
        .q_o(strap_s)
    );
    sync_bit u_sync_fit_a (
        .clock_i(clock_i),
        .reset_n_i(reset_n_i),
        .d_i(switch_pair_a_fitted_i),
        .q_o(fit_a_s)
    );
    sync_bit u_sync_fit_b (
        .clock_i(clock_i),
        .reset_n_i(reset_n_i),
        .d_i(switch_pair_b_fitted_i),
        .q_o(fit_b_s)
    );
    sync_bit u_sync_batt (
        .clock_i(clock_i),
        .reset_n_i(reset_n_i),
        .d_i(battery_above_minimum_i),
        .q_o(batt_ok_s)
    );

    // ****************************************
    // power-on capture of straps and fit detection
    // ****************************************
    logic [1:0] boot_cnt_reg;
    logic boot_done;
    logic strap_load;
    logic lock_a_reg;
    logic lock_b_reg;

    // two cycles for the synchronisers to settle after release
    assign boot_done = (boot_cnt_reg == 2'h3);
    assign strap_load = (boot_cnt_reg == 2'h2);

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            boot_cnt_reg <= 2'h0;
            lock_a_reg <= 1'b1;
            lock_b_reg <= 1'b1;
        end else if (!boot_done) begin
            boot_cnt_reg <= boot_cnt_reg + 2'h1;
            if (strap_load) begin
                lock_a_reg <= !fit_a_s;
                lock_b_reg <= !fit_b_s;
            end
        end
    end

    // ****************************************
    // write decode
    // ****************************************
    logic wr_four;
    logic wr_five;
    logic [7:0] wd;
    logic soft_rst;
    logic wd_rst;

    assign wr_four = req_i.wr && (req_i.addr == charger_ctrl_pkg::CTRL_FOUR_ADDR);
    assign wr_five = req_i.wr && (req_i.addr == charger_ctrl_pkg::CTRL_FIVE_ADDR);
    assign wd = req_i.wdata;
    assign soft_rst = register_reset_i;
    assign wd_rst = register_reset_i || watchdog_expired_i;

    // ****************************************
    // control four
    // ****************************************
    logic [7:0] four_reg;
    logic [7:0] four_next;
    logic lock_b;
    logic lock_a;
    logic det_next;

    assign lock_a = lock_a_reg || input_switch_drive_kill_i;
    assign lock_b = lock_b_reg || input_switch_drive_kill_i;
    // request taken only with battery above minimum; a new request beats a same-cycle done
    assign det_next = (wr_four && wd[charger_ctrl_pkg::F4_VLIM_DET] && batt_ok_s) ||
        (four_reg[charger_ctrl_pkg::F4_VLIM_DET] && !detect_done_i);

    always_comb begin
        four_next = four_reg;
        if (wr_four) begin
            four_next = (four_reg & ~charger_ctrl_pkg::CTRL_FOUR_WMASK)
                | (wd & charger_ctrl_pkg::CTRL_FOUR_WMASK);
        end
        four_next[charger_ctrl_pkg::F4_VLIM_DET] = det_next;
        if (wd_rst) begin
            four_next[charger_ctrl_pkg::F4_IND_OFF] = 1'b0;
        end
        if (soft_rst) begin
            four_next[charger_ctrl_pkg::F4_SHORT_OFF] = 1'b0;
            four_next[charger_ctrl_pkg::F4_VLIM_DET] = 1'b0;
            four_next[charger_ctrl_pkg::F4_IN_OCP] = 1'b1;
            four_next[charger_ctrl_pkg::F4_SWITCH_A] = 1'b0;
            four_next[charger_ctrl_pkg::F4_SWITCH_B] = 1'b0;
        end
        if (lock_b) begin
            four_next[charger_ctrl_pkg::F4_SWITCH_B] = 1'b0;
        end
        if (lock_a) begin
            four_next[charger_ctrl_pkg::F4_SWITCH_A] = 1'b0;
        end
        if (strap_load) begin
            four_next[charger_ctrl_pkg::F4_RATE_SEL] = strap_s;
        end
        four_next[2] = 1'b0;
    end

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            four_reg <= charger_ctrl_pkg::CTRL_FOUR_RESET;
        end else begin
            four_reg <= four_next;
        end
    end

    // ****************************************
    // control five
    // ****************************************
    logic [7:0] five_reg;
    logic [7:0] five_next;
    logic fitted;

    assign fitted = five_reg[charger_ctrl_pkg::F5_SHIP_FITTED];

    always_comb begin
        five_next = five_reg;
        if (wr_five) begin
            five_next = (five_reg & ~charger_ctrl_pkg::CTRL_FIVE_WMASK)
                | (wd & charger_ctrl_pkg::CTRL_FIVE_WMASK);
        end
        if (wd_rst) begin
            five_next[charger_ctrl_pkg::F5_BATTERY_CURRENT_OUT_PIN_OUT] = 1'b0;
            five_next[charger_ctrl_pkg::F5_INT_LIM] = 1'b1;
            five_next[charger_ctrl_pkg::F5_DIS_OC] = 1'b0;
        end
        if (soft_rst) begin
            five_next[charger_ctrl_pkg::F5_PIN_LIM] = 1'b1;
            five_next[charger_ctrl_pkg::F5_SHIP_FITTED] = 1'b0;
        end
        // gated bit uses current fitted state so a same-write unlock is not enough
        if (!fitted) begin
            five_next[charger_ctrl_pkg::F5_DIS_OC] = 1'b0;
        end
        five_next[6] = 1'b0;
        five_next[4:3] = charger_ctrl_pkg::CTRL_FIVE_FIXED[4:3];
    end

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            five_reg <= charger_ctrl_pkg::CTRL_FIVE_RESET;
        end else begin
            five_reg <= five_next;
        end
    end

    // ****************************************
    // read mux and outputs
    // ****************************************
    logic [7:0] rd_mux;

    assign rd_mux = (req_i.addr == charger_ctrl_pkg::CTRL_FOUR_ADDR) ? four_reg :
        (req_i.addr == charger_ctrl_pkg::CTRL_FIVE_ADDR) ? five_reg : 8'h00;

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rdata_o <= 8'h00;
            ctrl_o <= '0;
            detect_stop_switching_o <= 1'b0;
            ship_force_off_o <= 1'b0;
            ship_action_o <= 2'h0;
        end else begin
            if (req_i.rd) begin
                rdata_o <= rd_mux;
            end
            ctrl_o.switch_b_drive_en <= four_reg[charger_ctrl_pkg::F4_SWITCH_B];
            ctrl_o.switch_a_drive_en <= four_reg[charger_ctrl_pkg::F4_SWITCH_A];
            ctrl_o.switching_rate_sel <= four_reg[charger_ctrl_pkg::F4_RATE_SEL];
            ctrl_o.indicator_pin_off <= four_reg[charger_ctrl_pkg::F4_IND_OFF];
            ctrl_o.system_short_guard_off <= four_reg[charger_ctrl_pkg::F4_SHORT_OFF];
            ctrl_o.input_overcurrent_guard_en <= four_reg[charger_ctrl_pkg::F4_IN_OCP];
            ctrl_o.battery_current_out_en <= five_reg[charger_ctrl_pkg::F5_BATTERY_CURRENT_OUT_PIN_OUT];
            ctrl_o.internal_current_limit_en <= five_reg[charger_ctrl_pkg::F5_INT_LIM];
            ctrl_o.pin_current_limit_en <= five_reg[charger_ctrl_pkg::F5_PIN_LIM];
            ctrl_o.discharge_overcurrent_en <= five_reg[charger_ctrl_pkg::F5_DIS_OC];
            ctrl_o.ship_switch_fitted <= fitted;
            detect_stop_switching_o <= four_reg[charger_ctrl_pkg::F4_VLIM_DET];
            ship_force_off_o <= fitted && ship_force_off_req_i;
            ship_action_o <= fitted ? ship_action_req_i : 2'h0;
        end
    end

endmodule

// ---- charger_ctrl_pkg.sv ----
package charger_ctrl_pkg;

    // ****************************************
    // register offsets
    // ****************************************
    localparam logic [7:0] CTRL_FOUR_ADDR = 8'h13;
    localparam logic [7:0] CTRL_FIVE_ADDR = 8'h14;

    // ****************************************
    // control four field positions
    // ****************************************
    localparam int F4_SWITCH_B = 7;
    localparam int F4_SWITCH_A = 6;
    localparam int F4_RATE_SEL = 5;
    localparam int F4_IND_OFF = 4;
    localparam int F4_SHORT_OFF = 3;
    localparam int F4_VLIM_DET = 1;
    localparam int F4_IN_OCP = 0;

    // ****************************************
    // control five field positions
    // ****************************************
    localparam int F5_SHIP_FITTED = 7;
    localparam int F5_BATTERY_CURRENT_OUT_PIN_OUT = 5;
    localparam int F5_INT_LIM = 2;
    localparam int F5_PIN_LIM = 1;
    localparam int F5_DIS_OC = 0;

    // ****************************************
    // reset values and fixed bits
    // ****************************************
    localparam logic [7:0] CTRL_FOUR_RESET = 8'h01;
    localparam logic [7:0] CTRL_FIVE_RESET = 8'h16;
    localparam logic [7:0] CTRL_FIVE_FIXED = 8'h10;
    localparam logic [7:0] CTRL_FOUR_WMASK = 8'hfb;
    localparam logic [7:0] CTRL_FIVE_WMASK = 8'ha7;

    // ****************************************
    // carriers
    // ****************************************
    typedef struct packed {
        logic switch_b_drive_en;
        logic switch_a_drive_en;
        logic switching_rate_sel;
        logic indicator_pin_off;
        logic system_short_guard_off;
        logic input_overcurrent_guard_en;
        logic battery_current_out_en;
        logic internal_current_limit_en;
        logic pin_current_limit_en;
        logic discharge_overcurrent_en;
        logic ship_switch_fitted;
    } charger_ctrl_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

endpackage

// ---- sync_bit.sv ----
`timescale 1ns/1ps
module sync_bit #(
    parameter logic RESET_VALUE = 1'b0
) (
    // clock and reset
    input wire logic clock_i,
    input wire logic reset_n_i,
    // data
    input wire logic d_i,
    output logic q_o
);

    logic meta_reg;

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            meta_reg <= RESET_VALUE;
            q_o <= RESET_VALUE;
        end else begin
            meta_reg <= d_i;
            q_o <= meta_reg;
        end
    end

endmodule

// ---- charger_control_regs_4_5_asserts.sv ----
`timescale 1ns/1ps
module charger_control_regs_4_5_asserts (
    // clock and reset
    input wire logic clock_i,
    input wire logic reset_n_i,
    // watched ports
    input wire charger_ctrl_pkg::reg_req_t req_i,
    input wire logic [7:0] rdata_o,
    input wire logic register_reset_i,
    input wire logic watchdog_expired_i,
    input wire logic detect_done_i,
    input wire logic input_switch_drive_kill_i,
    input wire charger_ctrl_pkg::charger_ctrl_t ctrl_o,
    input wire logic detect_stop_switching_o,
    input wire logic ship_force_off_o,
    input wire logic [1:0] ship_action_o
);
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!reset_n_i);
    wire rd_four = req_i.rd && req_i.addr == charger_ctrl_pkg::CTRL_FOUR_ADDR;
    wire rd_five = req_i.rd && req_i.addr == charger_ctrl_pkg::CTRL_FIVE_ADDR;
    wire quiet_wd = watchdog_expired_i && !req_i.wr && !register_reset_i;
    wire wr_four = req_i.wr && req_i.addr == charger_ctrl_pkg::CTRL_FOUR_ADDR;
    wire done_alone = detect_done_i && !(wr_four && req_i.wdata[1]);
    sequence kill_held;
        input_switch_drive_kill_i [*3];
    endsequence
    sequence unfitted_held;
        !ctrl_o.ship_switch_fitted [*3];
    endsequence
    a_kill_forces_off: assert property (kill_held |->
        !ctrl_o.switch_a_drive_en && !ctrl_o.switch_b_drive_en) else $error("switch drive not off");
    a_ship_bits_gated: assert property (unfitted_held |-> !ship_force_off_o
        && ship_action_o == 2'h0 && !ctrl_o.discharge_overcurrent_en) else $error("ship bits open");
    a_detect_self_clear: assert property (done_alone |=> ##1
        !detect_stop_switching_o) else $error("detect not cleared");
    a_detect_needs_write: assert property ($rose(detect_stop_switching_o) |->
        $past(req_i.wr, 2) && $past(req_i.wdata[1], 2)
        && $past(req_i.addr, 2) == charger_ctrl_pkg::CTRL_FOUR_ADDR)
        else $error("detect without request");
    a_four_fixed_bit: assert property (rd_four |=> !rdata_o[2]) else $error("bad fixed bit");
    a_five_fixed_bits: assert property (rd_five |=>
        !rdata_o[6] && rdata_o[4:3] == 2'h2) else $error("bad fixed field");
    a_watchdog_clears: assert property (watchdog_expired_i |=> ##1
        !ctrl_o.indicator_pin_off && !ctrl_o.battery_current_out_en
        && ctrl_o.internal_current_limit_en && !ctrl_o.discharge_overcurrent_en)
        else $error("watchdog clear wrong");
    a_watchdog_spares: assert property (quiet_wd |=> ##1
        $stable(ctrl_o.system_short_guard_off) && $stable(ctrl_o.pin_current_limit_en))
        else $error("watchdog touched kept bits");
    a_regrst_defaults: assert property (register_reset_i |=> ##1
        ctrl_o.input_overcurrent_guard_en && ctrl_o.pin_current_limit_en
        && !ctrl_o.system_short_guard_off) else $error("register reset wrong");
endmodule

bind charger_control_regs_4_5 charger_control_regs_4_5_asserts i_chk (
    .clock_i(clock_i), .reset_n_i(reset_n_i), .req_i(req_i), .rdata_o(rdata_o),
    .register_reset_i(register_reset_i), .watchdog_expired_i(watchdog_expired_i),
    .detect_done_i(detect_done_i), .input_switch_drive_kill_i(input_switch_drive_kill_i),
    .ctrl_o(ctrl_o), .detect_stop_switching_o(detect_stop_switching_o),
    .ship_force_off_o(ship_force_off_o), .ship_action_o(ship_action_o));

// ---- host_model.sv ----
`timescale 1ns/1ps
module host_model (
    // clock
    input wire logic clock_i,
    // register access
    input wire logic [7:0] rdata_i,
    output charger_ctrl_pkg::reg_req_t req_o
);
    initial req_o = '0;
    // released lines carry inverted values so stale data never looks valid
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock_i);
        req_o <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clock_i);
        req_o <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock_i);
        req_o <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clock_i);
        req_o <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hff};
        @(posedge clock_i);
        d = rdata_i;
    endtask
endmodule

// ---- tb_charger_control_regs_4_5.sv ----
`timescale 1ns/1ps
module tb_charger_control_regs_4_5;
    logic clock_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic rr = 1'b0, wd = 1'b0, strap = 1'b1, bat = 1'b1, done = 1'b0, kill = 1'b0, fsr = 1'b0;
    logic [1:0] act = 2'h0;
    logic fa = 1'b1, fb = 1'b0;
    logic [1:0] sa;
    logic stop, fso;
    logic [7:0] rdata, got, d;
    logic [31:0] seed = 32'h5420;
    charger_ctrl_pkg::reg_req_t req;
    charger_ctrl_pkg::charger_ctrl_t ctrl;
    int errors = 0;
    int total_checks = 0;
    initial begin
        forever #12.5 clock_i = ~clock_i;
    end
    host_model host (.clock_i(clock_i), .rdata_i(rdata), .req_o(req));
    charger_control_regs_4_5 i_charger_control_regs_4_5 (
        .clock_i(clock_i), .reset_n_i(reset_n_i), .req_i(req), .rdata_o(rdata),
        .register_reset_i(rr), .watchdog_expired_i(wd), .configuration_strap_pin_i(strap),
        .switch_pair_a_fitted_i(fa), .switch_pair_b_fitted_i(fb),
        .battery_above_minimum_i(bat), .detect_done_i(done),
        .input_switch_drive_kill_i(kill), .ship_force_off_req_i(fsr),
        .ship_action_req_i(act), .ctrl_o(ctrl), .detect_stop_switching_o(stop),
        .ship_force_off_o(fso), .ship_action_o(sa));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    // pair b unfitted, bit 2 fixed, detect bit kept clear
    function automatic logic [7:0] four_exp(input logic [7:0] w);
        return w & 8'h79;
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge clock_i);
    endtask
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        total_checks++;
        if (g !== e) begin
            errors++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        host.rd(a, got);
        chk(got, e);
    endtask
    task automatic summarize();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge clock_i);
        errors++;
        summarize();
    end
    initial begin
        tick(2);
        reset_n_i <= 1'b1;
        tick(3);
        rchk(8'h13, 8'h21);
        rchk(8'h14, 8'h16);
        rchk(8'h20, 8'h00);
        chk({7'h0, ctrl.switching_rate_sel}, 8'h01);
        $display("reset test done");
        host.wr(8'h13, 8'hff);
        rchk(8'h13, 8'h7b);
        chk({7'h0, stop}, 8'h01);
        done <= 1'b1;
        tick(1);
        done <= 1'b0;
        tick(2);
        rchk(8'h13, 8'h79);
        bat <= 1'b0;
        tick(3);
        host.wr(8'h13, 8'h02);
        rchk(8'h13, 8'h00);
        $display("detect test done");
        for (int i = 0; i < 16; i++) begin
            seed = xs(seed);
            d = seed[7:0] & 8'hfd;
            kill <= seed[8];
            host.wr(8'h13, d);
            tick(2);
            chk({6'h0, ctrl.switch_b_drive_en, ctrl.switch_a_drive_en},
                {7'h0, d[6] & ~seed[8]});
            if (!seed[8]) begin
                rchk(8'h13, four_exp(d));
            end
        end
        kill <= 1'b0;
        $display("random test done");
        fsr <= 1'b1;
        act <= 2'h3;
        tick(3);
        chk({5'h0, fso, sa}, 8'h00);
        host.wr(8'h14, 8'hff);
        rchk(8'h14, 8'hb6);
        host.wr(8'h14, 8'hff);
        rchk(8'h14, 8'hb7);
        chk({5'h0, fso, sa}, 8'h07);
        host.wr(8'h13, 8'h18);
        host.wr(8'h14, 8'ha1);
        wd <= 1'b1;
        tick(1);
        wd <= 1'b0;
        tick(2);
        rchk(8'h13, 8'h08);
        rchk(8'h14, 8'h94);
        rr <= 1'b1;
        tick(1);
        rr <= 1'b0;
        tick(2);
        rchk(8'h13, 8'h01);
        rchk(8'h14, 8'h16);
        chk(ctrl[7:0], 8'h2c);
        chk({5'h0, ctrl[10:8]}, 8'h00);
        $display("ship and soft reset test done");
        // second power-on with the other strap level and fit pattern
        reset_n_i <= 1'b0;
        strap <= 1'b0;
        fa <= 1'b0;
        fb <= 1'b1;
        tick(2);
        reset_n_i <= 1'b1;
        tick(3);
        rchk(8'h13, 8'h01);
        host.wr(8'h13, 8'hff);
        rchk(8'h13, 8'hb9);
        chk({6'h0, ctrl.switch_b_drive_en, ctrl.switch_a_drive_en}, 8'h02);
        $display("second power-on test done");
        summarize();
    end
endmodule
